// ---- core/cag_core.sv ----
// cpu address generator: modes, xram addresses, dual pointers, interrupt vectoring
// assumes an apb master on clk and a sequencer pulsing instruction events
// ****************************************************************
// ****************************************************************
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
module cag_core
   import cag_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int FLASH_KB = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sequencer events
   input wire logic data_pointer_zero_inc,
   input wire logic data_pointer_zero_use,
   input wire logic movx_data_pointer_zero,
   input wire logic movx_ri,
   input wire logic [7:0] ri_value,
   input wire logic [7:0] port_two_latch,
   // xram address
   output logic [23:0] xram_addr,
   output logic xram_addr_valid,
   // mode outputs
   output logic flat_mode,
   output logic stack_mode_flag,
   // interrupt sources
   input wire logic [15:0] irq_req,
   input wire logic breakpoint_irq,
   input wire logic debug_irq,
   input wire logic [7:0] debug_req_id,
   // vectoring to the sequencer
   input wire logic irq_ack,
   output logic irq_pending,
   output logic [15:0] irq_vector
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   initial begin
      if (ADDR_W < 10) begin
         $error("cag_core: ADDR_W must be at least 10");
      end
      if (FLASH_KB != 16 && FLASH_KB != 32 && FLASH_KB != 48 && FLASH_KB != 64) begin
         $error("cag_core: FLASH_KB must be 16, 32, 48 or 64");
      end
   end

   // top hex digit of the relocated vector space
   localparam logic [3:0] VEC_DIGIT = 4'((FLASH_KB / 4) - 1);

   // ****************************************************************
   // functions
   // ****************************************************************
   // one pointer step; compatible mode keeps the top byte
   function automatic logic [23:0] ptr_step(input logic [23:0] p, input logic dec,
                                            input logic flat);
      logic [15:0] low;
      logic [7:0] top;
      begin
         low = dec ? p[15:0] - 16'h0001 : p[15:0] + 16'h0001;
         top = p[23:16];
         if (flat && !dec && p[15:0] == 16'hffff) begin
            top = top + 8'h01;
         end
         if (flat && dec && p[15:0] == 16'h0000) begin
            top = top - 8'h01;
         end
         ptr_step = {top, low};
      end
   endfunction

   // lowest natural number wins; slot 15 (ecc) outranks all
   function automatic logic [3:0] pick_slot(input logic [15:0] m);
      logic [3:0] idx;
      begin
         idx = 4'h0;
         for (int i = 14; i >= 0; i--) begin
            if (m[i]) begin
               idx = 4'(i);
            end
         end
         if (m[15]) begin
            idx = SLOT_TOP;
         end
         pick_slot = idx;
      end
   endfunction

   // ****************************************************************
   // registers
   // ****************************************************************
   cag_apb_state_t state_reg;
   logic [23:0] p0_reg, p1_reg;
   logic ptr_sel_reg, auto_toggle_sel_reg, step_dir_bit0_reg, step_dir_bit1_reg;
   logic addr_mode_bit0_reg, addr_mode_bit1_reg, indirect_high_src_sel_reg;
   logic vector_relocate_sel_reg;
   logic [7:0] indirect_move_high_byte_reg, indirect_move_top_byte_reg;
   logic [15:0] irq_en_reg, irq_prio_reg, irq_flag_reg;
   logic global_irq_enable_reg, dbg_port_en_reg, bkp_flag_reg, dbg_flag_reg;
   logic [7:0] dbg_id_reg;
   logic [3:0] irq_slot_reg;
   logic irq_special_reg;
   logic [31:0] prdata_reg;
   logic pready_reg, pslverr_reg, xram_valid_reg, pending_reg;
   logic [23:0] xram_addr_reg;
   logic [15:0] vector_reg;

   // ****************************************************************
   // apb decode
   // ****************************************************************
   wire in_range = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00);
   wire [7:0] idx = paddr[9:2];
   wire commit = psel && penable && pready_reg; // write lands only here
   wire wr = commit && pwrite && in_range;
   wire wr_p0_lo = wr && idx == IDX_P0_LOW;
   wire wr_p0_hi = wr && idx == IDX_P0_HIGH;
   wire wr_p0_top = wr && idx == IDX_P0_TOP;
   wire wr_p1_lo = wr && idx == IDX_P1_LOW;
   wire wr_p1_hi = wr && idx == IDX_P1_HIGH;
   wire wr_p1_top = wr && idx == IDX_P1_TOP;
   wire wr_select = wr && idx == IDX_PTR_SELECT;
   wire wr_mode = wr && idx == IDX_ADDR_MODE;
   wire wr_ind_hi = wr && idx == IDX_IND_HIGH;
   wire wr_ind_top = wr && idx == IDX_IND_TOP;
   wire wr_enable = wr && idx == IDX_IRQ_ENABLE;
   wire wr_prio = wr && idx == IDX_IRQ_PRIO;
   wire wr_flag = wr && idx == IDX_IRQ_FLAG;
   wire mapped = in_range && (idx == IDX_P0_LOW || idx == IDX_P0_HIGH ||
      idx == IDX_P1_LOW || idx == IDX_P1_HIGH || idx == IDX_PTR_SELECT ||
      idx == IDX_P0_TOP || idx == IDX_P1_TOP || idx == IDX_ADDR_MODE ||
      idx == IDX_IND_HIGH || idx == IDX_IND_TOP || idx == IDX_IRQ_ENABLE ||
      idx == IDX_IRQ_PRIO || idx == IDX_IRQ_FLAG || idx == IDX_IRQ_STATUS);

   // ****************************************************************
   // mode and pointer logic
   // ****************************************************************
   wire flat = addr_mode_bit1_reg; // 00 compatible, 1x flat
   wire stack_ext = flat; // flat mode moves the stack to data space
   wire [23:0] p0_step = ptr_step(p0_reg, step_dir_bit0_reg, flat);
   wire [23:0] p1_step = ptr_step(p1_reg, step_dir_bit1_reg, flat);
   wire ptr_used = data_pointer_zero_inc || data_pointer_zero_use || movx_data_pointer_zero;
   // bus writes win over sequencer updates of the same register
   wire [23:0] p0_next = wr_p0_lo ? {p0_reg[23:8], pwdata[7:0]} :
      wr_p0_hi ? {p0_reg[23:16], pwdata[7:0], p0_reg[7:0]} :
      wr_p0_top ? {pwdata[7:0], p0_reg[15:0]} :
      (data_pointer_zero_inc && !ptr_sel_reg) ? p0_step : p0_reg;
   wire [23:0] p1_next = wr_p1_lo ? {p1_reg[23:8], pwdata[7:0]} :
      wr_p1_hi ? {p1_reg[23:16], pwdata[7:0], p1_reg[7:0]} :
      wr_p1_top ? {pwdata[7:0], p1_reg[15:0]} :
      (data_pointer_zero_inc && ptr_sel_reg) ? p1_step : p1_reg;
   wire sel_next = wr_select ? pwdata[SEL_BIT] :
      (auto_toggle_sel_reg && ptr_used) ? !ptr_sel_reg : ptr_sel_reg;

   // ****************************************************************
   // xram address forming
   // ****************************************************************
   wire [23:0] sel_ptr = ptr_sel_reg ? p1_reg : p0_reg;
   wire [7:0] ri_high = indirect_high_src_sel_reg ? indirect_move_high_byte_reg
      : port_two_latch;
   // top byte from the indirect register only on indirect moves
   wire [23:0] ri_addr = {indirect_move_top_byte_reg, ri_high, ri_value};
   wire [23:0] xram_next = movx_ri ? ri_addr : sel_ptr;

   // ****************************************************************
   // interrupt flags and arbitration
   // ****************************************************************
   wire dbg_set = debug_irq && dbg_port_en_reg && debug_req_id == dbg_id_reg;
   wire [15:0] auto_clr = (irq_ack && !irq_special_reg &&
      (irq_slot_reg == SLOT_TIMER0 || irq_slot_reg == SLOT_TIMER1)) ?
      (16'h0001 << irq_slot_reg) : 16'h0000;
   wire [15:0] sw_clr = wr_flag ? pwdata[15:0] : 16'h0000;
   // set wins over any clear; writes never set
   wire [15:0] flag_next = (irq_flag_reg & ~(sw_clr | auto_clr)) | irq_req;
   wire bkp_next = (bkp_flag_reg && !(wr_flag && pwdata[BKP_FLAG_BIT])) || breakpoint_irq;
   wire dbg_next = (dbg_flag_reg && !(wr_flag && pwdata[DBG_FLAG_BIT])) || dbg_set;
   // per-source enable and global gate
   wire [15:0] eligible = irq_flag_reg & irq_en_reg & {16{global_irq_enable_reg}};
   wire [15:0] hi_set = eligible & irq_prio_reg; // two levels
   wire [15:0] lo_set = eligible & ~irq_prio_reg;
   wire [3:0] win_slot = pick_slot((hi_set != 16'h0000) ? hi_set : lo_set);
   wire [15:0] vec_base = vector_relocate_sel_reg ? {VEC_DIGIT, 12'h000}
      : HALF_RST;
   wire [15:0] slot_vec = vec_base | (VEC_FIRST + {9'h000, win_slot, 3'b000});
   // debug and breakpoint bypass the global gate
   wire special = dbg_flag_reg || bkp_flag_reg;
   wire [15:0] vec_next = dbg_flag_reg ? (vec_base | VEC_DBG) :
      bkp_flag_reg ? (vec_base | VEC_BKP) : slot_vec;
   wire pend_next = special || (eligible != 16'h0000);

   // ****************************************************************
   // apb read mux
   // ****************************************************************
   wire [7:0] select_rd = {step_dir_bit1_reg, step_dir_bit0_reg, auto_toggle_sel_reg,
      4'h0, ptr_sel_reg};
   wire [7:0] mode_rd = {2'b00, vector_relocate_sel_reg, 1'b0, indirect_high_src_sel_reg,
      stack_ext, addr_mode_bit1_reg, addr_mode_bit0_reg};
   wire [31:0] rd_data = !in_range ? 32'h0000_0000 :
      idx == IDX_P0_LOW ? {24'h000000, p0_reg[7:0]} :
      idx == IDX_P0_HIGH ? {24'h000000, p0_reg[15:8]} :
      idx == IDX_P0_TOP ? {24'h000000, p0_reg[23:16]} :
      idx == IDX_P1_LOW ? {24'h000000, p1_reg[7:0]} :
      idx == IDX_P1_HIGH ? {24'h000000, p1_reg[15:8]} :
      idx == IDX_P1_TOP ? {24'h000000, p1_reg[23:16]} :
      idx == IDX_PTR_SELECT ? {24'h000000, select_rd} :
      idx == IDX_ADDR_MODE ? {24'h000000, mode_rd} :
      idx == IDX_IND_HIGH ? {24'h000000, indirect_move_high_byte_reg} :
      idx == IDX_IND_TOP ? {24'h000000, indirect_move_top_byte_reg} :
      idx == IDX_IRQ_ENABLE ? {dbg_id_reg, 6'h00, dbg_port_en_reg, global_irq_enable_reg,
         irq_en_reg} :
      idx == IDX_IRQ_PRIO ? {16'h0000, irq_prio_reg} :
      idx == IDX_IRQ_FLAG ? {14'h0000, dbg_flag_reg, bkp_flag_reg, irq_flag_reg} :
      idx == IDX_IRQ_STATUS ? {15'h0000, pending_reg, vector_reg} : 32'h0000_0000;

   // ****************************************************************
   // apb sequencing: one wait state, answer registered
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= CAG_ST_IDLE;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         case (state_reg)
            CAG_ST_IDLE: begin
               if (psel && penable) begin
                  state_reg <= CAG_ST_ANSWER;
                  pready_reg <= 1'b1;
                  pslverr_reg <= !mapped;
                  prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
               end
            end
            CAG_ST_ANSWER: begin
               state_reg <= CAG_ST_IDLE;
               pready_reg <= 1'b0;
               pslverr_reg <= 1'b0;
            end
            default: begin
               state_reg <= CAG_ST_IDLE;
               pready_reg <= 1'b0;
            end
         endcase
      end
   end

   // pointer and mode state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         p0_reg <= 24'h000000;
         p1_reg <= 24'h000000;
         ptr_sel_reg <= 1'b0;
         {step_dir_bit1_reg, step_dir_bit0_reg, auto_toggle_sel_reg} <= 3'b000;
         {addr_mode_bit1_reg, addr_mode_bit0_reg} <= 2'b00;
         indirect_high_src_sel_reg <= 1'b0;
         vector_relocate_sel_reg <= 1'b0;
         indirect_move_high_byte_reg <= BYTE_RST;
         indirect_move_top_byte_reg <= BYTE_RST;
      end else begin
         p0_reg <= p0_next;
         p1_reg <= p1_next;
         ptr_sel_reg <= sel_next;
         if (wr_select) begin
            step_dir_bit1_reg <= pwdata[STEP1_BIT];
            step_dir_bit0_reg <= pwdata[STEP0_BIT];
            auto_toggle_sel_reg <= pwdata[TOGGLE_BIT];
         end
         if (wr_mode) begin // stack flag bit is not writable
            addr_mode_bit1_reg <= pwdata[AM1_BIT];
            addr_mode_bit0_reg <= pwdata[AM0_BIT];
            indirect_high_src_sel_reg <= pwdata[HISRC_BIT];
            vector_relocate_sel_reg <= pwdata[VECREL_BIT];
         end
         if (wr_ind_hi) begin
            indirect_move_high_byte_reg <= pwdata[7:0];
         end
         if (wr_ind_top) begin
            indirect_move_top_byte_reg <= pwdata[7:0];
         end
      end
   end

   // interrupt state; vector follows the flags one edge later
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_en_reg <= HALF_RST;
         irq_prio_reg <= HALF_RST;
         irq_flag_reg <= HALF_RST;
         {global_irq_enable_reg, dbg_port_en_reg} <= 2'b00;
         dbg_id_reg <= BYTE_RST;
         {bkp_flag_reg, dbg_flag_reg} <= 2'b00;
         irq_slot_reg <= 4'h0;
         irq_special_reg <= 1'b0;
         pending_reg <= 1'b0;
         vector_reg <= HALF_RST;
      end else begin
         if (wr_enable) begin
            irq_en_reg <= pwdata[15:0];
            global_irq_enable_reg <= pwdata[GLOBAL_BIT];
            dbg_port_en_reg <= pwdata[DBGPORT_BIT];
            dbg_id_reg <= pwdata[DBGID_LSB+7:DBGID_LSB];
         end
         if (wr_prio) begin
            irq_prio_reg <= pwdata[15:0];
         end
         irq_flag_reg <= flag_next;
         bkp_flag_reg <= bkp_next;
         dbg_flag_reg <= dbg_next;
         irq_slot_reg <= win_slot;
         irq_special_reg <= special;
         pending_reg <= pend_next;
         vector_reg <= vec_next;
      end
   end

   // xram address and its valid strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         xram_addr_reg <= 24'h000000;
         xram_valid_reg <= 1'b0;
      end else begin
         xram_addr_reg <= (movx_ri || movx_data_pointer_zero) ? xram_next : xram_addr_reg;
         xram_valid_reg <= movx_ri || movx_data_pointer_zero;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign xram_addr = xram_addr_reg;
   assign xram_addr_valid = xram_valid_reg;
   assign flat_mode = addr_mode_bit1_reg;
   assign stack_mode_flag = addr_mode_bit1_reg;
   assign irq_pending = pending_reg;
   assign irq_vector = vector_reg;

   // ****************************************************************
   // assertions
   // ****************************************************************
   property p_vec_space;
      @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> irq_vector[15:12] ==
         ($past(vector_relocate_sel_reg) ? VEC_DIGIT : 4'h0);
   endproperty
   a_vec_space: assert property (p_vec_space) else $error("vector space wrong");

   property p_ri_high;
      @(posedge clk) disable iff (!rst_n)
      movx_ri |=> xram_addr[15:8] == ($past(indirect_high_src_sel_reg) ?
         $past(indirect_move_high_byte_reg) : $past(port_two_latch));
   endproperty
   a_ri_high: assert property (p_ri_high) else $error("indirect high byte wrong");

   property p_ri_top;
      @(posedge clk) disable iff (!rst_n)
      movx_ri |=> xram_addr_valid && xram_addr[23:16] == $past(indirect_move_top_byte_reg)
         && xram_addr[7:0] == $past(ri_value);
   endproperty
   a_ri_top: assert property (p_ri_top) else $error("indirect top or low wrong");

   property p_data_pointer_zero_addr;
      @(posedge clk) disable iff (!rst_n)
      (movx_data_pointer_zero && !movx_ri) |=> xram_addr == ($past(ptr_sel_reg) ? $past(p1_reg)
         : $past(p0_reg));
   endproperty
   a_data_pointer_zero_addr: assert property (p_data_pointer_zero_addr) else $error("pointer address wrong");

   property p_step_large;
      @(posedge clk) disable iff (!rst_n)
      (data_pointer_zero_inc && !ptr_sel_reg && !flat && !wr) |=> p0_reg[23:16] == $past(p0_reg[23:16])
         && p0_reg[15:0] == ($past(step_dir_bit0_reg) ? $past(p0_reg[15:0]) - 16'h0001
         : $past(p0_reg[15:0]) + 16'h0001);
   endproperty
   a_step_large: assert property (p_step_large) else $error("pointer step wrong");

   property p_flat_carry;
      @(posedge clk) disable iff (!rst_n)
      (data_pointer_zero_inc && ptr_sel_reg && flat && !wr && !step_dir_bit1_reg &&
         p1_reg[15:0] == 16'hffff) |=> p1_reg[23:16] == $past(p1_reg[23:16]) + 8'h01;
   endproperty
   a_flat_carry: assert property (p_flat_carry) else $error("flat carry missing");

   property p_toggle;
      @(posedge clk) disable iff (!rst_n)
      (auto_toggle_sel_reg && movx_data_pointer_zero && !wr_select) |=> ptr_sel_reg != $past(ptr_sel_reg);
   endproperty
   a_toggle: assert property (p_toggle) else $error("auto toggle missing");

   property p_no_sw_set;
      @(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> (irq_flag_reg & ~$past(irq_flag_reg) & ~$past(irq_req)) == 16'h0000;
   endproperty
   a_no_sw_set: assert property (p_no_sw_set) else $error("flag set without request");

   property p_high_first;
      @(posedge clk) disable iff (!rst_n)
      (hi_set != 16'h0000 && !special) |=> irq_pending && irq_prio_reg[irq_slot_reg];
   endproperty
   a_high_first: assert property (p_high_first) else $error("low level beat high");

   property p_dbg_wins;
      @(posedge clk) disable iff (!rst_n)
      (dbg_flag_reg && !global_irq_enable_reg) |=> irq_pending && irq_vector[11:0] == 12'h0c0;
   endproperty
   a_dbg_wins: assert property (p_dbg_wins) else $error("debug vector wrong");

   property p_timer_clear;
      @(posedge clk) disable iff (!rst_n)
      (irq_ack && !irq_special_reg && irq_slot_reg == SLOT_TIMER0 && !irq_req[1])
         |=> !irq_flag_reg[1];
   endproperty
   a_timer_clear: assert property (p_timer_clear) else $error("timer flag kept");

endmodule

// ---- core/cag_pkg.sv ----
// constants for the cpu address generator and interrupt vectoring block
// assumes a 32-bit apb slave; printed register offsets are word indices
package cag_pkg;

   // ****************************************************************
   // register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [7:0] IDX_P0_LOW = 8'h82;
   localparam logic [7:0] IDX_P0_HIGH = 8'h83;
   localparam logic [7:0] IDX_P1_LOW = 8'h84;
   localparam logic [7:0] IDX_P1_HIGH = 8'h85;
   localparam logic [7:0] IDX_PTR_SELECT = 8'h86;
   localparam logic [7:0] IDX_P0_TOP = 8'h93;
   localparam logic [7:0] IDX_P1_TOP = 8'h95;
   localparam logic [7:0] IDX_ADDR_MODE = 8'h9d;
   localparam logic [7:0] IDX_IND_HIGH = 8'hda;
   localparam logic [7:0] IDX_IND_TOP = 8'hea;
   localparam logic [7:0] IDX_IRQ_ENABLE = 8'ha8;
   localparam logic [7:0] IDX_IRQ_PRIO = 8'hb8;
   localparam logic [7:0] IDX_IRQ_FLAG = 8'hc0;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hc1;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int SEL_BIT = 0;
   localparam int TOGGLE_BIT = 5;
   localparam int STEP0_BIT = 6;
   localparam int STEP1_BIT = 7;
   localparam int AM0_BIT = 0;
   localparam int AM1_BIT = 1;
   localparam int STACK_BIT = 2;
   localparam int HISRC_BIT = 3;
   localparam int VECREL_BIT = 5;
   localparam int GLOBAL_BIT = 16;
   localparam int DBGPORT_BIT = 17;
   localparam int DBGID_LSB = 24;
   localparam int BKP_FLAG_BIT = 16;
   localparam int DBG_FLAG_BIT = 17;
   localparam int PEND_BIT = 16;

   // ****************************************************************
   // reset values and vector constants
   // ****************************************************************
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [15:0] HALF_RST = 16'h0000;
   localparam logic [15:0] VEC_FIRST = 16'h0003;
   localparam logic [15:0] VEC_BKP = 16'h0080;
   localparam logic [15:0] VEC_DBG = 16'h00c0;
   localparam logic [3:0] SLOT_TIMER0 = 4'h1;
   localparam logic [3:0] SLOT_TIMER1 = 4'h3;
   localparam logic [3:0] SLOT_TOP = 4'hf;

   // apb answer sequencing
   typedef enum logic [1:0] {
      CAG_ST_IDLE = 2'b01,
      CAG_ST_ANSWER = 2'b10
   } cag_apb_state_t;

endpackage

// ---- bench/cag_seq_model.sv ----
// sequencer model: enters the routine shown a few cycles after pending rises
// assumes irq_pending is registered on clk; go lets the bench hold entry back
`timescale 1ns/100ps
module cag_seq_model (
   // clock and vector handshake
   input wire logic clk,
   input wire logic go,
   input wire logic irq_pending,
   output logic irq_ack
);
   int cnt = 0;
   initial irq_ack = 1'b0;
   // slow entry on purpose, so the vector has to stand while we wait
   always @(posedge clk) begin
      cnt <= (go && irq_pending && !irq_ack) ? cnt + 1 : 0;
      irq_ack <= (cnt == 2);
   end
endmodule

// ---- bench/tb.sv ----
// bench for cag_core: apb registers, xram addresses, pointer steps, vectoring
// assumes a one wait state apb answer and vectors two edges after a request
`timescale 1ns/100ps
module tb;
   import cag_pkg::*;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, go = 0, fl, d, err;
   logic data_pointer_zero_inc = 0, data_pointer_zero_use = 0, movx_data_pointer_zero = 0, movx_ri = 0, breakpoint_irq = 0;
   logic debug_irq = 0, irq_ack, pready, pslverr, xram_addr_valid, flat_mode;
   logic stack_mode_flag, irq_pending;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [7:0] ri_value = 0, port_two_latch = 0, debug_req_id = 0;
   logic [15:0] irq_req = 0, irq_vector;
   logic [23:0] xram_addr, b, v;
   logic [7:0] ix [10] = '{IDX_P0_LOW, IDX_P0_HIGH, IDX_P1_LOW, IDX_P1_HIGH, IDX_PTR_SELECT,
      IDX_P0_TOP, IDX_P1_TOP, IDX_ADDR_MODE, IDX_IND_HIGH, IDX_IND_TOP};
   int fail_count = 0, tests_run = 0, cyc = 0;
   cag_core dut (.*);
   cag_seq_model seq (.clk, .go, .irq_pending, .irq_ack);
   initial forever #20 clk = ~clk;
   // hang guard, far above the fewer than a thousand cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer; an idle edge after it keeps drivers single per step
   task automatic apb(input logic [7:0] idx, input logic [31:0] wd, input logic wr = 1);
      int n = 0;
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, 2'b00, idx, 2'b00, wd};
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
      @(posedge clk);
   endtask
   task automatic ev(input logic [3:0] e);
      {data_pointer_zero_inc, data_pointer_zero_use, movx_data_pointer_zero, movx_ri} <= e;
      @(posedge clk);
      {data_pointer_zero_inc, data_pointer_zero_use, movx_data_pointer_zero, movx_ri} <= 4'h0;
      @(posedge clk);
   endtask
   function automatic logic [23:0] nx(logic [23:0] p, logic dn, logic f);
      nx = dn ? p - 1 : p + 1;
      if (!f) nx[23:16] = p[23:16];
   endfunction
   function automatic logic [15:0] vec(int k, logic r);
      return {r ? 4'h7 : 4'h0, 12'h003 + 12'(8 * k)};
   endfunction
   initial begin
      void'($urandom(32'h5be1efc1));
      repeat (20) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      foreach (ix[j]) begin
         apb(ix[j], 0, 0);
         chk(rd, 0);
      end
      apb(8'h10, $urandom);
      chk(err, 1);
      // each pass: one pointer and step code, a carry edge, then two interrupts
      for (int i = 0; i < 8; i++) begin
         fl = 1'($urandom);
         d = i[2] ? i[1] : i[0];
         b = {8'($urandom), d ? 16'h0000 : 16'hffff};
         apb(i[2] ? IDX_P1_LOW : IDX_P0_LOW, {24'h0, b[7:0]});
         apb(i[2] ? IDX_P1_HIGH : IDX_P0_HIGH, {24'h0, b[15:8]});
         apb(i[2] ? IDX_P1_TOP : IDX_P0_TOP, {24'h0, b[23:16]});
         apb(IDX_ADDR_MODE, {26'h0, i[0], 1'b0, i[1] ^ i[2], 1'b1, fl, i[1]});
         apb(IDX_ADDR_MODE, 0, 0);
         chk(rd, {26'h0, i[0], 1'b0, i[1] ^ i[2], fl, fl, i[1]});
         chk(flat_mode, fl);
         apb(IDX_PTR_SELECT, {24'h0, i[1:0], 5'h0, i[2]});
         ev(4'h8);
         ev(4'h2);
         chk({xram_addr_valid, xram_addr}, {1'b1, nx(b, d, fl)});
         apb(IDX_PTR_SELECT, {26'h1, 4'h0, i[2]});
         ev(4'h4);
         apb(IDX_PTR_SELECT, 0, 0);
         chk(rd, {26'h1, 4'h0, ~i[2]});
         v = 24'($urandom);
         {ri_value, port_two_latch} <= 16'($urandom);
         apb(IDX_IND_HIGH, {24'h0, v[15:8]});
         apb(IDX_IND_TOP, {24'h0, v[23:16]});
         ev(4'h1);
         chk(xram_addr, {v[23:16], (i[1] ^ i[2]) ? v[15:8] : port_two_latch, ri_value});
         // global gate off before the new requests, so no stale pending
         apb(IDX_IRQ_ENABLE, 32'(3 << (i + 1)));
         irq_req <= 16'(3 << (i + 1));
         repeat (2) @(posedge clk);
         chk(irq_pending, 0);
         apb(IDX_IRQ_PRIO, 32'(2 << (i + 1)));
         apb(IDX_IRQ_ENABLE, 32'h10000 | 32'(3 << (i + 1)));
         repeat (2) @(posedge clk);
         chk({irq_pending, irq_vector}, {1'b1, vec(i + 2, i[0])});
         irq_req <= 0;
         go <= 1;
         repeat (6) @(posedge clk);
         go <= 0;
         chk(irq_vector, vec(i == 1 ? 2 : i + 2, i[0]));
         // routine reads the flags to find the sharing source
         apb(IDX_IRQ_FLAG, 0, 0);
         chk(rd[15:0], i == 1 ? 16'h0004 : 16'(3 << (i + 1)));
         apb(IDX_IRQ_FLAG, '1);
         repeat (2) @(posedge clk);
         chk(irq_pending, 0);
      end
      // debug and breakpoint with global gate off; relocation still on
      apb(IDX_IRQ_ENABLE, 32'h5a02_0000);
      {breakpoint_irq, debug_irq, debug_req_id} <= {2'b11, 8'h5a};
      @(posedge clk);
      {breakpoint_irq, debug_irq} <= 2'b00;
      repeat (2) @(posedge clk);
      chk({irq_pending, irq_vector}, {1'b1, 16'h70c0});
      apb(IDX_IRQ_FLAG, 32'h0002_0000);
      repeat (2) @(posedge clk);
      chk({irq_pending, irq_vector}, {1'b1, 16'h7080});
      finish_test();
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
endmodule
